//--- rtl/sscr_regs.sv
// Slot status, device capabilities/control/status 2 and link capabilities 2 for a downstream port.
// Assumes configuration accesses arrive on core_clk_i, one strobe per cycle, never read and write together.
//
// Overview of operation
// - Attention button press sets sticky bit 16
// - Power fault latches bit 17, write-one clears
// - Latch sensor change sets read-only bit 18
// - Presence change latches bit 19, write-one clears
// - Finished hot-plug command sets bit 20
// - Bit 21 shows live latch sensor, open=1
// - Bit 22 shows card presence, present=1
// - No slot implemented: presence bit reads one
// - Link-active change sets bit 24, write-one clears
// - Capability bit 11 reads one, read-only
// - Flush/fill hint support bits 19:18, reset 00
// - Capability bit 12 resets zero, loadable default
// - Control bits 14:13 writable hint enable, reset 00
// - Interrupt needs event enable and global enable
`timescale 1ns/1ns
`include "sscr_defs.svh"

module sscr_regs (
	input  wire logic                     core_clk_i,
	input  wire logic                     srst_i,
	input  wire logic [`SSCR_ADDR_W-1:0]  addr_i,
	input  wire logic [`SSCR_DATA_W-1:0]  wdata_i,
	input  wire logic                     wr_i,
	input  wire logic                     rd_i,
	output logic      [`SSCR_DATA_W-1:0]  rdata_o,
	input  wire logic                     attn_button_i,
	input  wire logic                     power_fault_i,
	input  wire logic                     mrl_open_i,
	input  wire logic                     card_present_i,
	input  wire logic                     cmd_done_i,
	input  wire logic                     link_active_i,
	input  wire logic                     slot_implemented_i,
	input  wire logic                     cap_load_i,
	input  wire logic                     cap_fc_ltr_i,
	input  wire logic [1:0]               cap_obff_i,
	output logic                          hp_irq_o,
	output logic                          ltr_en_o,
	output logic      [1:0]               obff_en_o
);

	// ********************************
	// Access decode
	// ********************************
	sscr_pkg::sscr_cfg_req_t req;
	sscr_pkg::sscr_slot_evt_t evt;
	logic                     hit_slot;
	logic                     hit_cap2;
	logic                     hit_ctl2;
	logic                     hit_lcap2;
	logic                     wr_slot;
	logic                     wr_ctl2;

	// Bundle the bus inputs so decode reads one carrier
	assign req.wr    = wr_i;
	assign req.rd    = rd_i;
	assign req.addr  = addr_i;
	assign req.wdata = wdata_i;

	assign hit_slot  = (req.addr == `SSCR_OFS_SLOT);
	assign hit_cap2  = (req.addr == `SSCR_OFS_DEVCAP2);
	assign hit_ctl2  = (req.addr == `SSCR_OFS_DEVCTL2);
	assign hit_lcap2 = (req.addr == `SSCR_OFS_LINKCAP2);
	assign wr_slot   = req.wr & hit_slot;
	assign wr_ctl2   = req.wr & hit_ctl2;

	// ********************************
	// Sensor pins
	// ********************************
	// Pins come from the slot and are asynchronous, so each passes two flops first
	sscr_pin_sync u_sync_attn (
		.core_clk_i (core_clk_i),
		.srst_i     (srst_i),
		.pin_i      (attn_button_i),
		.level_o    (),
		.rise_o     (evt.attn_rise),
		.change_o   ()
	);

	sscr_pin_sync u_sync_fault (
		.core_clk_i (core_clk_i),
		.srst_i     (srst_i),
		.pin_i      (power_fault_i),
		.level_o    (),
		.rise_o     (evt.fault_rise),
		.change_o   ()
	);

	sscr_pin_sync u_sync_mrl (
		.core_clk_i (core_clk_i),
		.srst_i     (srst_i),
		.pin_i      (mrl_open_i),
		.level_o    (evt.mrl_open),
		.rise_o     (),
		.change_o   (evt.mrl_change)
	);

	sscr_pin_sync u_sync_pres (
		.core_clk_i (core_clk_i),
		.srst_i     (srst_i),
		.pin_i      (card_present_i),
		.level_o    (evt.present),
		.rise_o     (),
		.change_o   (evt.present_change)
	);

	// Link-active comes from the same clock domain, so a single history flop is enough
	logic link_active_prev;
	logic link_change;

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			link_active_prev <= 1'b0;
		end else begin
			link_active_prev <= link_active_i;
		end
	end

	assign link_change = link_active_i ^ link_active_prev;

	// ********************************
	// Slot status event flags
	// ********************************
	logic st_abp;
	logic st_pf;
	logic st_mrlc;
	logic st_pdc;
	logic st_cc;
	logic st_dll;

	sscr_sticky_bit u_st_abp (
		.core_clk_i (core_clk_i),
		.srst_i     (srst_i),
		.set_i      (evt.attn_rise),
		.clr_i      (wr_slot & req.wdata[`SSCR_ST_ABP_BIT]),
		.flag_o     (st_abp)
	);

	sscr_sticky_bit u_st_pf (
		.core_clk_i (core_clk_i),
		.srst_i     (srst_i),
		.set_i      (evt.fault_rise),
		.clr_i      (wr_slot & req.wdata[`SSCR_ST_PF_BIT]),
		.flag_o     (st_pf)
	);

	// Read-only change flag: software cannot clear it, only reset does
	sscr_sticky_bit u_st_mrlc (
		.core_clk_i (core_clk_i),
		.srst_i     (srst_i),
		.set_i      (evt.mrl_change),
		.clr_i      (1'b0),
		.flag_o     (st_mrlc)
	);

	sscr_sticky_bit u_st_pdc (
		.core_clk_i (core_clk_i),
		.srst_i     (srst_i),
		.set_i      (evt.present_change),
		.clr_i      (wr_slot & req.wdata[`SSCR_ST_PDC_BIT]),
		.flag_o     (st_pdc)
	);

	sscr_sticky_bit u_st_cc (
		.core_clk_i (core_clk_i),
		.srst_i     (srst_i),
		.set_i      (cmd_done_i),
		.clr_i      (wr_slot & req.wdata[`SSCR_ST_CC_BIT]),
		.flag_o     (st_cc)
	);

	sscr_sticky_bit u_st_dll (
		.core_clk_i (core_clk_i),
		.srst_i     (srst_i),
		.set_i      (link_change),
		.clr_i      (wr_slot & req.wdata[`SSCR_ST_DLL_BIT]),
		.flag_o     (st_dll)
	);

	// ********************************
	// Slot control enables and interrupt
	// ********************************
	logic [15:0] slot_ctl;

	// Only the enable bits are held; the rest of the control half belongs elsewhere
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			slot_ctl <= `SSCR_SLOTCTL_RST;
		end else if (wr_slot) begin
			slot_ctl <= req.wdata[15:0] & `SSCR_SLOTCTL_MASK;
		end
	end

	// Level interrupt: drops as soon as software clears the flag or an enable
	assign hp_irq_o = slot_ctl[`SSCR_EN_HPI_BIT] &
		((st_abp & slot_ctl[`SSCR_EN_ABP_BIT]) |
		 (st_pf  & slot_ctl[`SSCR_EN_PF_BIT])  |
		 (st_mrlc & slot_ctl[`SSCR_EN_MRL_BIT]) |
		 (st_pdc & slot_ctl[`SSCR_EN_PDC_BIT]) |
		 (st_cc  & slot_ctl[`SSCR_EN_CC_BIT])  |
		 (st_dll & slot_ctl[`SSCR_EN_DLL_BIT]));

	// ********************************
	// Capabilities 2 and control 2
	// ********************************
	logic       cap_fc_ltr;
	logic [1:0] cap_obff;
	logic       ctl_ltr_en;
	logic [1:0] ctl_obff_en;

	// Defaults may be replaced by the side-band loader; software never writes them
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			cap_fc_ltr <= `SSCR_CAP_FCLTR_RST;
			cap_obff   <= `SSCR_CAP_OBFF_RST;
		end else if (cap_load_i) begin
			cap_fc_ltr <= cap_fc_ltr_i;
			cap_obff   <= cap_obff_i;
		end
	end

	// Writable enables; all other control bits are dropped on write
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			ctl_ltr_en  <= 1'b0;
			ctl_obff_en <= `SSCR_CTL_OBFF_RST;
		end else if (wr_ctl2) begin
			ctl_ltr_en  <= req.wdata[`SSCR_CTL_LTR_BIT];
			ctl_obff_en <= req.wdata[`SSCR_CTL_OBFF_LSB +: 2];
		end
	end

	assign ltr_en_o  = ctl_ltr_en;
	assign obff_en_o = ctl_obff_en;

	// ********************************
	// Read path
	// ********************************
	logic [`SSCR_DATA_W-1:0] next_rdata;
	logic                    pres_rd;

	// Without a slot the presence bit is forced so software sees a card
	assign pres_rd = slot_implemented_i ? evt.present : 1'b1;

	// Unmapped addresses and reserved bits read zero
	always_comb begin
		next_rdata = `SSCR_ZERO_WORD;
		if (hit_slot) begin
			next_rdata[15:0]              = slot_ctl;
			next_rdata[`SSCR_ST_ABP_BIT]  = st_abp;
			next_rdata[`SSCR_ST_PF_BIT]   = st_pf;
			next_rdata[`SSCR_ST_MRLC_BIT] = st_mrlc;
			next_rdata[`SSCR_ST_PDC_BIT]  = st_pdc;
			next_rdata[`SSCR_ST_CC_BIT]   = st_cc;
			next_rdata[`SSCR_ST_MRLS_BIT] = evt.mrl_open;
			next_rdata[`SSCR_ST_PRES_BIT] = pres_rd;
			next_rdata[`SSCR_ST_DLL_BIT]  = st_dll;
		end else if (hit_cap2) begin
			next_rdata[`SSCR_CAP_LTR_BIT]        = 1'b1;
			next_rdata[`SSCR_CAP_FCLTR_BIT]      = cap_fc_ltr;
			next_rdata[`SSCR_CAP_OBFF_LSB +: 2]  = cap_obff;
		end else if (hit_ctl2) begin
			next_rdata[`SSCR_CTL_LTR_BIT]        = ctl_ltr_en;
			next_rdata[`SSCR_CTL_OBFF_LSB +: 2]  = ctl_obff_en;
		end
	end

	// Data stands only in the cycle after the read strobe
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			rdata_o <= `SSCR_ZERO_WORD;
		end else if (req.rd) begin
			rdata_o <= next_rdata;
		end else begin
			rdata_o <= `SSCR_ZERO_WORD;
		end
	end

	// ********************************
	// Checks
	// ********************************
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (srst_i);

	sequence s_slot_read;
		rd_i && addr_i == `SSCR_OFS_SLOT;
	endsequence

	sequence s_abp_clear;
		wr_i && addr_i == `SSCR_OFS_SLOT && wdata_i[`SSCR_ST_ABP_BIT] && !evt.attn_rise;
	endsequence

	AST_ABP_SET: assert property (evt.attn_rise |=> st_abp)
		else $error("attention flag not set after press");
	AST_ABP_CLR: assert property (s_abp_clear |=> !st_abp)
		else $error("attention flag not cleared by write one");
	AST_PF_HOLD: assert property (st_pf && !(wr_slot && wdata_i[`SSCR_ST_PF_BIT]) |=> st_pf)
		else $error("power fault flag dropped without a clear");
	AST_MRLC_RO: assert property (st_mrlc |=> st_mrlc)
		else $error("latch change flag cleared by software");
	AST_PDC_SET: assert property (evt.present_change |=> st_pdc)
		else $error("presence change not latched");
	AST_CC_SET: assert property (cmd_done_i |=> st_cc)
		else $error("command completed flag not set");
	AST_MRLS_LIVE: assert property (s_slot_read |=> rdata_o[`SSCR_ST_MRLS_BIT] == $past(evt.mrl_open))
		else $error("latch state bit does not follow sensor");
	AST_PRES_NOSLOT: assert property (s_slot_read ##0 !slot_implemented_i |=> rdata_o[`SSCR_ST_PRES_BIT])
		else $error("presence bit not forced without a slot");
	AST_DLL_SET: assert property ($changed(link_active_i) |=> st_dll)
		else $error("link active change not latched");
	AST_CAP2_READ: assert property (rd_i && hit_cap2 |=> rdata_o[`SSCR_CAP_LTR_BIT] &&
		rdata_o[`SSCR_CAP_OBFF_LSB +: 2] == $past(cap_obff))
		else $error("capability 2 read value wrong");
	AST_CTL2_WR: assert property (wr_ctl2 |=> obff_en_o == $past(wdata_i[14:13]) &&
		ltr_en_o == $past(wdata_i[10]))
		else $error("control 2 enables not written");
	AST_ZERO_READ: assert property (rd_i && (hit_lcap2 || !(hit_slot || hit_cap2 || hit_ctl2))
		|=> rdata_o == `SSCR_ZERO_WORD)
		else $error("zero register read nonzero");
	AST_IRQ_GATE: assert property (!slot_ctl[`SSCR_EN_HPI_BIT] |-> !hp_irq_o)
		else $error("interrupt raised while globally disabled");

endmodule

//--- shared/sscr_defs.svh
// Offsets, field positions, reset values and widths for the slot status and capability-2 slice.
// Assumes it is included by its bare name from any file that needs a constant.
`ifndef SSCR_DEFS_SVH
`define SSCR_DEFS_SVH

// ********************************
// Bus shape
// ********************************
`define SSCR_ADDR_W           12
`define SSCR_DATA_W           32

// ********************************
// Register offsets (byte addresses)
// ********************************
`define SSCR_OFS_SLOT         12'h0d8
`define SSCR_OFS_DEVCAP2      12'h0e4
`define SSCR_OFS_DEVCTL2      12'h0e8
`define SSCR_OFS_LINKCAP2     12'h0ec

// ********************************
// Slot control enables, low half of the slot word
// ********************************
`define SSCR_EN_ABP_BIT       0
`define SSCR_EN_PF_BIT        1
`define SSCR_EN_MRL_BIT       2
`define SSCR_EN_PDC_BIT       3
`define SSCR_EN_CC_BIT        4
`define SSCR_EN_HPI_BIT       5
`define SSCR_EN_DLL_BIT       12
`define SSCR_SLOTCTL_MASK     16'h103f
`define SSCR_SLOTCTL_RST      16'h0000

// ********************************
// Slot status, high half of the slot word
// ********************************
`define SSCR_ST_ABP_BIT       16
`define SSCR_ST_PF_BIT        17
`define SSCR_ST_MRLC_BIT      18
`define SSCR_ST_PDC_BIT       19
`define SSCR_ST_CC_BIT        20
`define SSCR_ST_MRLS_BIT      21
`define SSCR_ST_PRES_BIT      22
`define SSCR_ST_DLL_BIT       24

// ********************************
// Device capabilities 2, control 2, link capabilities 2
// ********************************
`define SSCR_CAP_LTR_BIT      11
`define SSCR_CAP_FCLTR_BIT    12
`define SSCR_CAP_OBFF_LSB     18
`define SSCR_CAP_FCLTR_RST    1'h0
`define SSCR_CAP_OBFF_RST     2'h0
`define SSCR_CTL_LTR_BIT      10
`define SSCR_CTL_OBFF_LSB     13
`define SSCR_CTL_OBFF_RST     2'h0
`define SSCR_ZERO_WORD        32'h0000_0000

`endif

//--- shared/sscr_pkg.sv
// Types shared by the slot status and capability-2 register slice.
// Assumes sscr_defs.svh is on the include path.
`include "sscr_defs.svh"

package sscr_pkg;

	// ********************************
	// Carriers
	// ********************************
	// One configuration access as seen by the register file
	typedef struct packed {
		logic                      wr;
		logic                      rd;
		logic [`SSCR_ADDR_W-1:0]   addr;
		logic [`SSCR_DATA_W-1:0]   wdata;
	} sscr_cfg_req_t;

	// Synchronised sensor levels with their one-cycle edge pulses
	typedef struct packed {
		logic attn_rise;
		logic fault_rise;
		logic mrl_open;
		logic mrl_change;
		logic present;
		logic present_change;
	} sscr_slot_evt_t;

endpackage

//--- rtl/sscr_pin_sync.sv
// Two-flop synchroniser with rise and change pulses for one slot sensor pin.
// Assumes the pin is asynchronous to core_clk_i and the reset is synchronous.
`timescale 1ns/1ns

module sscr_pin_sync (
	input  wire logic core_clk_i,
	input  wire logic srst_i,
	input  wire logic pin_i,
	output logic      level_o,
	output logic      rise_o,
	output logic      change_o
);

	logic meta;
	logic stable;
	logic prev;

	// First flop feeds only the second one, so no metastable value reaches logic
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			meta   <= 1'b0;
			stable <= 1'b0;
			prev   <= 1'b0;
		end else begin
			meta   <= pin_i;
			stable <= meta;
			prev   <= stable;
		end
	end

	// Edge pulses compare the settled level with its previous sample
	assign level_o  = stable;
	assign rise_o   = stable & ~prev;
	assign change_o = stable ^ prev;

endmodule

//--- rtl/sscr_sticky_bit.sv
// One sticky event flag, set by hardware and optionally cleared by writing one.
// Assumes set_i and clr_i are single-cycle terms on core_clk_i.
`timescale 1ns/1ns

module sscr_sticky_bit (
	input  wire logic core_clk_i,
	input  wire logic srst_i,
	input  wire logic set_i,
	input  wire logic clr_i,
	output logic      flag_o
);

	// Set wins over clear so an event landing on the clear cycle is kept
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			flag_o <= 1'b0;
		end else begin
			flag_o <= set_i | (flag_o & ~clr_i);
		end
	end

endmodule

//--- bench/sscr_slot_model.sv
// Slot sensors and hot-plug controller as seen from the register slice.
// Assumes the bench calls its tasks from one process only.
`timescale 1ns/1ns

module sscr_slot_model (
	input  wire logic core_clk_i,
	output logic      attn_button_o,
	output logic      power_fault_o,
	output logic      mrl_open_o,
	output logic      card_present_o,
	output logic      link_active_o,
	output logic      cmd_done_o
);
	// ********************************
	// Sensor levels and command pulse
	// ********************************
	// Quiet slot at power-up: no card, latch closed, link down
	initial begin
		{attn_button_o, power_fault_o, mrl_open_o, card_present_o, link_active_o} = 5'h00;
		cmd_done_o = 1'h0;
	end

	// All levels move together just after an edge
	task set_pins(input logic [4:0] v);
		@(posedge core_clk_i);
		{attn_button_o, power_fault_o, mrl_open_o, card_present_o, link_active_o} <= v;
	endtask

	// A full clock wide, so it can never be missed
	task cmd_pulse();
		@(posedge core_clk_i);
		cmd_done_o <= 1'h1;
		@(posedge core_clk_i);
		cmd_done_o <= 1'h0;
	endtask
endmodule

//--- bench/sscr_regs_tb.sv
// Self-checking bench for the slot status and capability-2 slice.
// Assumes the slice's own assertions sit in its design files.
`timescale 1ns/1ns
`include "sscr_defs.svh"

module sscr_regs_tb;
	logic        clk, srst, wr_s, rd_s, rd_d, irq, ltr, slot_impl, cap_load, cap_fc;
	logic [11:0] addr;
	logic [31:0] wdata, rdata, exp_q[$], msk_q[$], e, m, seed, r;
	logic [1:0]  obff, cap_obff;
	logic        attn, pf, mrl, card, link, done;
	int          error_cnt, total_checks;

	// ********************************
	// Clock, design and partner
	// ********************************
	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end

	sscr_regs sscr_regs_i (.core_clk_i(clk), .srst_i(srst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr_s),
		.rd_i(rd_s), .rdata_o(rdata), .attn_button_i(attn), .power_fault_i(pf), .mrl_open_i(mrl),
		.card_present_i(card), .cmd_done_i(done), .link_active_i(link), .slot_implemented_i(slot_impl),
		.cap_load_i(cap_load), .cap_fc_ltr_i(cap_fc), .cap_obff_i(cap_obff), .hp_irq_o(irq),
		.ltr_en_o(ltr), .obff_en_o(obff));

	sscr_slot_model sscr_slot_model_i (.core_clk_i(clk), .attn_button_o(attn), .power_fault_o(pf),
		.mrl_open_o(mrl), .card_present_o(card), .link_active_o(link), .cmd_done_o(done));

	// ********************************
	// Checking
	// ********************************
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Read data is looked at only in the one cycle it stands, zero elsewhere
	always @(posedge clk) rd_d <= rd_s;
	always @(negedge clk) begin
		if (rd_d) begin
			e = exp_q.pop_front();
			m = msk_q.pop_front();
			chk("rdata", e & m, rdata & m);
		end else if (!srst) begin
			chk("rdata_idle", 32'h0000_0000, rdata);
		end
	end

	task stop_test();
		if (error_cnt == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// ********************************
	// Bus master
	// ********************************
	task wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'h1;
		@(posedge clk);
		wr_s <= 1'h0;
	endtask

	// The expectation is noted before the strobe goes out
	task rd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] msk);
		@(posedge clk);
		exp_q.push_back(exp);
		msk_q.push_back(msk);
		addr <= a;
		rd_s <= 1'h1;
		@(posedge clk);
		rd_s <= 1'h0;
	endtask

	function automatic logic [31:0] xs(input logic [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction

	// Hang guard: the whole run takes well under 1000 cycles
	initial begin
		#100000;
		error_cnt++;
		stop_test();
	end

	// ********************************
	// Scenarios
	// ********************************
	initial begin
		error_cnt = 0;
		total_checks = 0;
		seed = 32'h0000_6ada;
		// Reset high, no strobes, slot present, loader idle
		{srst, wr_s, rd_s, rd_d, slot_impl, cap_load, cap_fc} = 7'h44;
		addr = 12'h000;
		wdata = 32'h0000_0000;
		cap_obff = 2'h0;
		repeat (4) @(posedge clk);
		srst <= 1'h0;
		// Reset values, then an unmapped place
		rd(`SSCR_OFS_SLOT, 32'h0000_0000, 32'hffff_ffff);
		rd(`SSCR_OFS_DEVCAP2, 32'h0000_0800, 32'hffff_ffff);
		rd(`SSCR_OFS_DEVCTL2, 32'h0000_0000, 32'hffff_ffff);
		rd(`SSCR_OFS_LINKCAP2, 32'h0000_0000, 32'hffff_ffff);
		rd(12'h0dc, 32'h0000_0000, 32'hffff_ffff);
		// Writes to read-only words and reserved bits change nothing
		wr(`SSCR_OFS_DEVCAP2, 32'hffff_ffff);
		wr(`SSCR_OFS_LINKCAP2, 32'hffff_ffff);
		wr(`SSCR_OFS_SLOT, 32'hffff_ffff);
		rd(`SSCR_OFS_DEVCAP2, 32'h0000_0800, 32'hffff_ffff);
		rd(`SSCR_OFS_LINKCAP2, 32'h0000_0000, 32'hffff_ffff);
		rd(`SSCR_OFS_SLOT, 32'h0000_103f, 32'hffff_ffff);
		// Random control words: only the two enable fields hold
		repeat (4) begin
			seed = xs(seed);
			r = seed;
			wr(`SSCR_OFS_DEVCTL2, r);
			rd(`SSCR_OFS_DEVCTL2, r & 32'h0000_6400, 32'hffff_ffff);
			chk("ltr_en", {31'h0000_0000, r[10]}, {31'h0000_0000, ltr});
			chk("obff_en", {30'h0000_0000, r[14:13]}, {30'h0000_0000, obff});
		end
		// Every event at once with all enables off
		wr(`SSCR_OFS_SLOT, 32'h0000_0000);
		sscr_slot_model_i.set_pins(5'h1f);
		sscr_slot_model_i.cmd_pulse();
		repeat (5) @(posedge clk);
		rd(`SSCR_OFS_SLOT, 32'h017f_0000, 32'hffff_ffff);
		chk("irq_off", 32'h0000_0000, {31'h0000_0000, irq});
		// Write one clears all but the read-only change flag and live states
		sscr_slot_model_i.set_pins(5'h07);
		repeat (4) @(posedge clk);
		wr(`SSCR_OFS_SLOT, 32'h01ff_103f);
		rd(`SSCR_OFS_SLOT, 32'h0064_103f, 32'hffff_ffff);
		chk("irq_mrl", 32'h0000_0001, {31'h0000_0000, irq});
		wr(`SSCR_OFS_SLOT, 32'h0000_103b);
		@(posedge clk);
		chk("irq_masked", 32'h0000_0000, {31'h0000_0000, irq});
		sscr_slot_model_i.cmd_pulse();
		repeat (2) @(posedge clk);
		chk("irq_cmd", 32'h0000_0001, {31'h0000_0000, irq});
		rd(`SSCR_OFS_SLOT, 32'h0074_103b, 32'hffff_ffff);
		wr(`SSCR_OFS_SLOT, 32'h0000_101b);
		@(posedge clk);
		chk("irq_global", 32'h0000_0000, {31'h0000_0000, irq});
		// Link drops and card leaves: both changes latch again
		sscr_slot_model_i.set_pins(5'h04);
		repeat (5) @(posedge clk);
		rd(`SSCR_OFS_SLOT, 32'h013c_101b, 32'hffff_ffff);
		// No slot behind the port: presence reads one with no card
		slot_impl <= 1'h0;
		rd(`SSCR_OFS_SLOT, 32'h0040_0000, 32'h0040_0000);
		// Loaded capability defaults
		@(posedge clk);
		// Load strobe high, flow-control bit one, hint support 10
		{cap_load, cap_fc, cap_obff} <= 4'he;
		@(posedge clk);
		cap_load <= 1'h0;
		rd(`SSCR_OFS_DEVCAP2, 32'h0008_1800, 32'hffff_ffff);
		// Second reset in mid-run clears flags, enables and controls
		@(posedge clk);
		srst <= 1'h1;
		repeat (3) @(posedge clk);
		srst <= 1'h0;
		rd(`SSCR_OFS_SLOT, 32'h0000_0000, 32'h011b_ffff);
		rd(`SSCR_OFS_DEVCTL2, 32'h0000_0000, 32'hffff_ffff);
		// Loaded capability values fall back to their defaults
		rd(`SSCR_OFS_DEVCAP2, 32'h0000_0800, 32'hffff_ffff);
		chk("irq_reset", 32'h0000_0000, {31'h0000_0000, irq});
		repeat (3) @(posedge clk);
		stop_test();
	end
endmodule
